// *** verilog/mpf_pin_select.sv ***
// Multi-use pin function selector: LCD, general I/O and peripheral routing
`default_nettype none
module mpf_pin_select #(
  parameter int GIO_LINES = mpf_pkg::GIO_W // Number of shared I/O lines
) (
  input wire logic ref_clk_i, // 40 MHz system clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic debug_port_enable_pin_i, // Emulator strap pin
  input wire logic push_button_input_i, // Button pin
  input wire logic low_power_mode_i, // Sleep or LCD-only mode
  input wire logic button_flag_clear_i, // Clear of the button flag
  output logic button_event_flag_o, // Sticky button flag
  output logic wake_o, // Wake pulse
  input wire logic [GIO_LINES-1:0] gio_lcd_sel_i, // 1: line drives LCD
  input wire logic [GIO_LINES-1:0] gio_lcd_i, // LCD waveform per line
  input wire logic [GIO_LINES-1:0] gio_out_i, // I/O output data
  input wire logic [GIO_LINES-1:0] gio_oe_i, // I/O output enable
  input wire logic [GIO_LINES-1:0] gio_pin_i, // Line pin level
  output logic [GIO_LINES-1:0] gio_pin_o, // Line pin drive value
  output logic [GIO_LINES-1:0] gio_pin_oe_o, // Line pin enable
  output logic [GIO_LINES-1:0] gio_in_o, // Synced line levels
  input wire logic eeprom_sel_i, // Two-wire interface selected
  input wire logic eeprom_sck_i, // Two-wire clock
  input wire logic eeprom_sda_low_i, // Pull data low
  output logic eeprom_sda_o, // Synced data level
  input wire logic pulse_sel_i, // Pulse outputs selected
  input wire logic energy_pulse_out_i, // Energy pulse
  input wire logic reactive_pulse_out_i, // Reactive pulse
  input wire logic aux_pulse_x_i, // Auxiliary X pulse
  input wire logic aux_pulse_y_i, // Auxiliary Y pulse
  input wire logic optical_receive_sel_i, // Line 1 as optical receive
  output logic optical_receive_o, // UART receive data
  input wire logic optical_transmit_sel_i, // Line 2 as optical transmit
  input wire logic optical_transmit_i, // LED transmit data
  input wire logic uart_remap_enable_i, // Alternate UART on 18/22
  input wire logic uart_remap_select_i, // 0: transmit on 18, 1: on 22
  input wire logic alt_uart_transmit_i, // Alternate UART transmit
  output logic alt_uart_receive_o, // Alternate UART receive
  input wire logic [mpf_pkg::SEG_N-1:0] seg_lcd_i, // LCD waveform per shared seg
  input wire logic [mpf_pkg::SEG_N-1:0] seg_pin_i, // Shared seg pin level
  output logic [mpf_pkg::SEG_N-1:0] seg_pin_o, // Shared seg drive value
  output logic [mpf_pkg::SEG_N-1:0] seg_pin_oe_o, // Shared seg enable
  input wire logic spi_sel_i, // Slave SPI port selected
  input wire logic spi_port_out_i, // SPI serial output
  output logic spi_clk_o, // SPI clock in
  output logic spi_port_select_n_o, // SPI select, active low
  output logic spi_port_in_o, // SPI serial in
  input wire logic emulator_data_out_i, // Emulator data drive
  input wire logic emulator_data_oe_i, // Emulator data enable
  input wire logic emulator_trace_clock_i, // Emulator trace clock
  output logic emulator_serial_data_o, // Emulator data in
  output logic emulator_reset_o, // Emulator reset in
  output logic debug_port_active_o, // Synced strap
  input wire logic trace_sel_i, // Trace bus selected
  input wire logic [mpf_pkg::TRACE_W-1:0] trace_bus_bit_i, // Trace bus
  input wire logic trace_sync_out_i, // Trace sync drive
  input wire logic trace_sync_oe_i, // Trace sync enable
  output logic trace_sync_break_request_o, // Break request in
  input wire logic clock_out_enable_i, // Clock test on seg 19
  input wire logic clock_test_output_i, // Clock to show
  input wire logic mux_sync_enable_i, // Mux sync on seg 7
  input wire logic mux_sync_output_i, // Mux sync signal
  input wire logic [mpf_pkg::TEST_MUX_SELECT_W-1:0] test_mux_select_i, // Test mux select
  input wire logic [mpf_pkg::TEST_MUX_SELECT_N-1:0] test_mux_src_i, // Test mux sources
  output logic test_mux_output_o // Test mux pin
);
  import mpf_pkg::*;

  // Elaboration check: the fixed-function lines reach up to line 22
  if (GIO_LINES < GIO_W)
  begin : gio_lines_check
    $error("GIO_LINES too small for fixed function lines");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [GIO_LINES-1:0] gio_meta; // First stage only feeds gio_sync
  logic [GIO_LINES-1:0] gio_sync;
  logic [SEG_N-1:0] seg_meta;
  logic [SEG_N-1:0] seg_sync;
  logic strap_meta;
  logic strap_sync;

  // Two flops on every pin level coming from outside
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      gio_meta <= '0;
      gio_sync <= '0;
      seg_meta <= '0;
      seg_sync <= '0;
      strap_meta <= RST_LVL;
      strap_sync <= RST_LVL;
    end
    else
    begin
      gio_meta <= gio_pin_i;
      gio_sync <= gio_meta;
      seg_meta <= seg_pin_i;
      seg_sync <= seg_meta;
      strap_meta <= debug_port_enable_pin_i;
      strap_sync <= strap_meta;
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  logic [GIO_LINES-1:0] gpo;
  logic [GIO_LINES-1:0] gpe;
  logic [SEG_N-1:0] spo;
  logic [SEG_N-1:0] spe;
  logic [GIO_LINES-1:0] next_gpo;
  logic [GIO_LINES-1:0] next_gpe;
  logic [SEG_N-1:0] next_spo;
  logic [SEG_N-1:0] next_spe;
  logic next_optical_receive;
  logic next_alt_rx;
  logic next_test_mux_select;
  logic optical_receive;
  logic alt_rx;
  logic test_mux_select;

  // Next pin drive; later overrides win, so peripheral selects beat LCD/I/O mode
  always_comb
  begin
    for (int i = 0; i < GIO_LINES; i++)
    begin
      next_gpo[i] = gio_lcd_sel_i[i] ? gio_lcd_i[i] : gio_out_i[i];
      next_gpe[i] = gio_lcd_sel_i[i] | gio_oe_i[i];
    end
    if (eeprom_sel_i)
    begin
      next_gpo[GIO_EE_SCK] = eeprom_sck_i;
      next_gpe[GIO_EE_SCK] = 1'b1;
      next_gpo[GIO_EE_SDA] = 1'b0;
      next_gpe[GIO_EE_SDA] = eeprom_sda_low_i; // Open drain: enable only to pull low
    end
    if (pulse_sel_i)
    begin
      next_gpo[GIO_PULSE_E] = energy_pulse_out_i;
      next_gpo[GIO_PULSE_R] = reactive_pulse_out_i;
      next_gpo[GIO_PULSE_X] = aux_pulse_x_i;
      next_gpo[GIO_PULSE_Y] = aux_pulse_y_i;
      next_gpe[GIO_PULSE_Y:GIO_PULSE_E] = 4'hF;
    end
    if (optical_receive_sel_i)
    begin
      next_gpe[GIO_OPTICAL_RECEIVE] = 1'b0;
    end
    if (optical_transmit_sel_i)
    begin
      next_gpo[GIO_OPTICAL_TRANSMIT] = optical_transmit_i;
      next_gpe[GIO_OPTICAL_TRANSMIT] = 1'b1;
    end
    if (uart_remap_enable_i)
    begin
      // Transmit pin drives, the other listens
      next_gpo[uart_remap_select_i ? GIO_UART_B : GIO_UART_A] = alt_uart_transmit_i;
      next_gpe[GIO_UART_A] = ~uart_remap_select_i;
      next_gpe[GIO_UART_B] = uart_remap_select_i;
    end
    // Receive paths idle high when not routed, so a UART never sees a false start
    next_optical_receive = optical_receive_sel_i ? gio_sync[GIO_OPTICAL_RECEIVE] : RST_RX_IDLE;
    next_alt_rx = RST_RX_IDLE;
    if (uart_remap_enable_i)
      next_alt_rx = uart_remap_select_i ? gio_sync[GIO_UART_A] : gio_sync[GIO_UART_B];
    // Shared segments default to LCD drive
    next_spo = seg_lcd_i;
    next_spe = '1;
    if (spi_sel_i)
    begin
      next_spe[SEG_SPI_CLK] = 1'b0;
      next_spe[SEG_SPI_SEL] = 1'b0;
      next_spe[SEG_SPI_IN] = 1'b0;
      next_spo[SEG_SPI_OUT] = spi_port_out_i;
      next_spe[SEG_SPI_OUT] = ~seg_sync[SEG_SPI_SEL]; // Release output while deselected
    end
    if (mux_sync_enable_i)
      next_spo[SEG_MUX_SYNC] = mux_sync_output_i;
    if (clock_out_enable_i)
      next_spo[SEG_CLK_TEST] = clock_test_output_i;
    // Strap low leaves segments 9-11 on the LCD defaults above
    if (strap_sync)
    begin
      next_spo[SEG_EMU_DATA] = emulator_data_out_i;
      next_spe[SEG_EMU_DATA] = emulator_data_oe_i;
      next_spo[SEG_EMU_TCLK] = emulator_trace_clock_i;
      next_spe[SEG_EMU_RST] = 1'b0;
    end
    if (trace_sel_i)
    begin
      next_spo[SEG_TRACE0 +: TRACE_W] = trace_bus_bit_i;
      next_spo[SEG_TRACE_HS] = trace_sync_out_i;
      next_spe[SEG_TRACE_HS] = trace_sync_oe_i;
    end
    next_test_mux_select = test_mux_src_i[test_mux_select_i];
  end

  // Pin drives, receive paths and the test mux output are registered so a function switches only on a clock edge
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      gpo <= '0;
      gpe <= '0;
      spo <= '0;
      spe <= '0;
      optical_receive <= RST_RX_IDLE;
      alt_rx <= RST_RX_IDLE;
      test_mux_select <= RST_LVL;
    end
    else
    begin
      gpo <= next_gpo;
      gpe <= next_gpe;
      spo <= next_spo;
      spe <= next_spe;
      optical_receive <= next_optical_receive;
      alt_rx <= next_alt_rx;
      test_mux_select <= next_test_mux_select;
    end
  end

  assign gio_pin_o = gpo;
  assign gio_pin_oe_o = gpe;
  assign gio_in_o = gio_sync;
  assign eeprom_sda_o = gio_sync[GIO_EE_SDA];
  assign optical_receive_o = optical_receive;
  assign alt_uart_receive_o = alt_rx;
  assign seg_pin_o = spo;
  assign seg_pin_oe_o = spe;
  assign spi_clk_o = seg_sync[SEG_SPI_CLK];
  assign spi_port_select_n_o = seg_sync[SEG_SPI_SEL];
  assign spi_port_in_o = seg_sync[SEG_SPI_IN];
  assign emulator_serial_data_o = seg_sync[SEG_EMU_DATA];
  assign emulator_reset_o = strap_sync & seg_sync[SEG_EMU_RST];
  assign debug_port_active_o = strap_sync;
  assign trace_sync_break_request_o = trace_sel_i & seg_sync[SEG_TRACE_HS];
  assign test_mux_output_o = test_mux_select;

  // ****************************************
  // Push button
  // ****************************************
  mpf_btn_if btn ();
  assign btn.low_power = low_power_mode_i;
  assign btn.flag_clear = button_flag_clear_i;

  mpf_button u_button (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .push_button_input_i(push_button_input_i),
    .btn(btn)
  );

  assign button_event_flag_o = btn.event_flag;
  assign wake_o = btn.wake;
endmodule
`default_nettype wire

// *** verilog/mpf_pkg.sv ***
// Package of pin positions, widths and reset values for the multi-use pin selector
`default_nettype none
package mpf_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int GIO_W = 23; // General I/O lines 0..22 on shared pins
  localparam int SEG_N = 14; // Shared segment-only pins
  localparam int TEST_MUX_SELECT_W = 4; // Test mux select width
  localparam int TEST_MUX_SELECT_N = 16; // Test mux inputs
  localparam int TRACE_W = 4; // Trace bus width
  // ****************************************
  // General I/O line positions
  // ****************************************
  localparam int GIO_OPTICAL_RECEIVE = 1; // Optical receive line
  localparam int GIO_OPTICAL_TRANSMIT = 2; // Optical transmit line
  localparam int GIO_EE_SCK = 4; // Two-wire serial clock
  localparam int GIO_EE_SDA = 5; // Two-wire serial data
  localparam int GIO_PULSE_E = 6; // Energy pulse
  localparam int GIO_PULSE_R = 7; // Reactive pulse
  localparam int GIO_PULSE_X = 8; // Auxiliary X pulse
  localparam int GIO_PULSE_Y = 9; // Auxiliary Y pulse
  localparam int GIO_UART_A = 18; // Alternate UART pin A
  localparam int GIO_UART_B = 22; // Alternate UART pin B
  // ****************************************
  // Shared segment pin positions
  // ****************************************
  localparam int SEG_SPI_CLK = 0; // Segment 3
  localparam int SEG_SPI_OUT = 1; // Segment 4
  localparam int SEG_SPI_SEL = 2; // Segment 5
  localparam int SEG_SPI_IN = 3; // Segment 6
  localparam int SEG_MUX_SYNC = 4; // Segment 7
  localparam int SEG_EMU_DATA = 5; // Segment 9
  localparam int SEG_EMU_TCLK = 6; // Segment 10
  localparam int SEG_EMU_RST = 7; // Segment 11
  localparam int SEG_CLK_TEST = 8; // Segment 19
  localparam int SEG_TRACE0 = 9; // Segments 51..54
  localparam int SEG_TRACE_HS = 13; // Segment 55
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_LVL = 1'b0; // Pin outputs and flags at reset
  localparam logic RST_RX_IDLE = 1'b1; // Idle level of a UART receive line
endpackage
`default_nettype wire

// *** verilog/mpf_btn_if.sv ***
// Interface between the pin selector and its push-button event unit
`default_nettype none
interface mpf_btn_if;
  logic low_power; // Device is in sleep or LCD-only mode
  logic flag_clear; // Software clear of the button flag
  logic event_flag; // Sticky button event flag
  logic wake; // One-cycle wake request
  modport core (input low_power, input flag_clear, output event_flag, output wake);
  modport top (output low_power, output flag_clear, input event_flag, input wake);
endinterface
`default_nettype wire

// *** verilog/mpf_button.sv ***
// Push-button synchroniser, rising-edge event flag and wake pulse
`default_nettype none
module mpf_button (
  input wire logic ref_clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic push_button_input_i, // Raw button pin
  mpf_btn_if.core btn // Flag and wake towards the selector
);
  import mpf_pkg::*;
  // ****************************************
  // Synchroniser and edge state
  // ****************************************
  logic pb_meta; // First stage, read only by pb_sync
  logic pb_sync; // Second stage
  logic pb_prev; // Previous synced level
  logic flag; // Sticky event
  logic wake; // Wake pulse
  logic next_flag;
  logic next_wake;
  logic rise;

  // Edge detect looks only at the settled stages
  always_comb
  begin
    rise = pb_sync & ~pb_prev;
    next_flag = (flag & ~btn.flag_clear) | rise;
    next_wake = rise & btn.low_power;
  end

  // Registers; reset holds every stage low as the idle button level
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      pb_meta <= RST_LVL;
      pb_sync <= RST_LVL;
      pb_prev <= RST_LVL;
      flag <= RST_LVL;
      wake <= RST_LVL;
    end
    else
    begin
      pb_meta <= push_button_input_i;
      pb_sync <= pb_meta;
      pb_prev <= pb_sync;
      flag <= next_flag;
      wake <= next_wake;
    end
  end

  assign btn.event_flag = flag;
  assign btn.wake = wake;
endmodule
`default_nettype wire

// *** tb/mpf_checker.sv ***
// Concurrent checks on routing and button timing of the pin selector
`default_nettype none
module mpf_checker
  import mpf_pkg::*;
#(
  parameter int GIO_LINES = GIO_W // Shared line count
) (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic pulse_sel_i, // Pulse mode
  input wire logic energy_pulse_out_i, // Energy pulse
  input wire logic [GIO_LINES-1:0] gio_pin_o, // Line drive
  input wire logic [GIO_LINES-1:0] gio_pin_oe_o, // Line enable
  input wire logic eeprom_sel_i, // Two-wire mode
  input wire logic eeprom_sck_i, // Two-wire clock
  input wire logic eeprom_sda_low_i, // Data pull low
  input wire logic uart_remap_enable_i, // Remap on
  input wire logic uart_remap_select_i, // Remap swap
  input wire logic alt_uart_transmit_i, // Remap transmit
  input wire logic [TEST_MUX_SELECT_W-1:0] test_mux_select_i, // Mux select
  input wire logic [TEST_MUX_SELECT_N-1:0] test_mux_src_i, // Mux sources
  input wire logic test_mux_output_o, // Mux pin
  input wire logic button_event_flag_o, // Button flag
  input wire logic button_flag_clear_i, // Flag clear
  input wire logic push_button_input_i, // Button pin
  input wire logic debug_port_active_o, // Synced strap
  input wire logic [SEG_N-1:0] seg_pin_oe_o, // Seg enable
  input wire logic wake_o // Wake pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Helpers and checks
  // ****************************************
  logic run_q; // Reset low at last edge
  logic run2; // Reset low at the last two edges, so pipelines hold real data
  // Settling flags, so nothing is judged on values from inside reset
  always_ff @(posedge ref_clk_i)
  begin
    run_q <= !sys_rst_i;
    run2 <= run_q && !sys_rst_i;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  pulse_route_a: assert property (run2 && pulse_sel_i |=>
    gio_pin_o[GIO_PULSE_E] == $past(energy_pulse_out_i) && gio_pin_oe_o[GIO_PULSE_Y]) else $error("Pulse not routed");
  eeprom_route_a: assert property (run2 && eeprom_sel_i |=> gio_pin_o[GIO_EE_SCK] == $past(eeprom_sck_i) &&
    gio_pin_oe_o[GIO_EE_SDA] == $past(eeprom_sda_low_i) && !gio_pin_o[GIO_EE_SDA]) else $error("Two-wire not routed");
  uart_tx_a: assert property (run2 && uart_remap_enable_i && !uart_remap_select_i |=>
    gio_pin_o[GIO_UART_A] == $past(alt_uart_transmit_i)) else $error("Remap transmit wrong");
  test_mux_select_pick_a: assert property ((run2 && $stable(test_mux_src_i) && $stable(test_mux_select_i)) [*3] |=>
    test_mux_output_o == $past(test_mux_src_i[test_mux_select_i])) else $error("Test mux wrong");
  flag_sticky_a: assert property (button_event_flag_o && !button_flag_clear_i |=>
    button_event_flag_o) else $error("Flag dropped");
  flag_clear_a: assert property ((run2 && !push_button_input_i) [*4] ##0 button_flag_clear_i |=>
    !button_event_flag_o) else $error("Flag not cleared");
  flag_rise_a: assert property (run2 && $rose(push_button_input_i) |-> ##[1:5] button_event_flag_o)
    else $error("Flag not set");
  wake_pulse_a: assert property (wake_o |-> button_event_flag_o ##1 !wake_o)
    else $error("Wake pulse wrong");
  emu_reset_in_a: assert property (debug_port_active_o |=> !seg_pin_oe_o[SEG_EMU_RST])
    else $error("Emulator reset pin driven");
  cover property (wake_o);
  cover property (run2 && uart_remap_enable_i && uart_remap_select_i);
  cover property (button_event_flag_o && button_flag_clear_i);
endmodule
bind mpf_pin_select mpf_checker #(.GIO_LINES(GIO_LINES)) chk_i (.*);
`default_nettype wire

// *** tb/mpf_pin_model.sv ***
// Board-side model: far parts drive whatever lines the selector leaves free
`default_nettype none
module mpf_pin_model
  import mpf_pkg::*;
(
  input wire logic [GIO_W-1:0] gio_pin_o, // Line drive
  input wire logic [GIO_W-1:0] gio_pin_oe_o, // Line enable
  input wire logic [GIO_W-1:0] gio_ext, // Far part levels
  input wire logic [SEG_N-1:0] seg_pin_o, // Seg drive
  input wire logic [SEG_N-1:0] seg_pin_oe_o, // Seg enable
  input wire logic [SEG_N-1:0] seg_ext, // Far part levels
  output logic [GIO_W-1:0] gio_pin_i, // Wire level
  output logic [SEG_N-1:0] seg_pin_i // Wire level
);
  timeunit 1ns;
  timeprecision 100ps;
  // Enabled bits carry the selector, others the board, so no stale value lingers
  assign gio_pin_i = (gio_pin_o & gio_pin_oe_o) | (gio_ext & ~gio_pin_oe_o);
  assign seg_pin_i = (seg_pin_o & seg_pin_oe_o) | (seg_ext & ~seg_pin_oe_o);
endmodule
`default_nettype wire

// *** tb/mpf_pin_select_tb.sv ***
// Self-checking bench for the multi-use pin selector
`default_nettype none
module mpf_pin_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mpf_pkg::*;
  // ****************************************
  // Signals, at rest from time zero
  // ****************************************
  logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, debug_port_enable_pin_i = 1'h0, push_button_input_i = 1'h0;
  logic low_power_mode_i = 1'h0, button_flag_clear_i = 1'h0, eeprom_sel_i = 1'h0, eeprom_sck_i = 1'h0;
  logic eeprom_sda_low_i = 1'h0, pulse_sel_i = 1'h0, energy_pulse_out_i = 1'h0, reactive_pulse_out_i = 1'h0;
  logic aux_pulse_x_i = 1'h0, aux_pulse_y_i = 1'h0, optical_receive_sel_i = 1'h0, optical_transmit_sel_i = 1'h0;
  logic optical_transmit_i = 1'h0, uart_remap_enable_i = 1'h0, uart_remap_select_i = 1'h0, spi_sel_i = 1'h0;
  logic alt_uart_transmit_i = 1'h0, spi_port_out_i = 1'h0, emulator_data_out_i = 1'h0, trace_sel_i = 1'h0;
  logic emulator_data_oe_i = 1'h0, emulator_trace_clock_i = 1'h0, trace_sync_out_i = 1'h0, trace_sync_oe_i = 1'h0;
  logic clock_out_enable_i = 1'h0, clock_test_output_i = 1'h0, mux_sync_enable_i = 1'h0, mux_sync_output_i = 1'h0;
  logic [GIO_W-1:0] gio_lcd_sel_i = 23'h0, gio_lcd_i = 23'h0, gio_out_i = 23'h0, gio_ext = 23'h0;
  logic [GIO_W-1:0] gio_oe_i = 23'h7FFFFF;
  logic [SEG_N-1:0] seg_lcd_i = 14'h0, seg_ext = 14'h0;
  logic [TRACE_W-1:0] trace_bus_bit_i = 4'h0;
  logic [TEST_MUX_SELECT_W-1:0] test_mux_select_i = 4'h0;
  logic [TEST_MUX_SELECT_N-1:0] test_mux_src_i = 16'h0;
  logic button_event_flag_o, wake_o, eeprom_sda_o, optical_receive_o, alt_uart_receive_o, spi_clk_o;
  logic spi_port_select_n_o, spi_port_in_o, emulator_serial_data_o, emulator_reset_o, debug_port_active_o;
  logic trace_sync_break_request_o, test_mux_output_o;
  logic [GIO_W-1:0] gio_pin_i, gio_pin_o, gio_pin_oe_o, gio_in_o;
  logic [SEG_N-1:0] seg_pin_i, seg_pin_o, seg_pin_oe_o;
  int bad_count = 0, tests_run = 0, cycles = 0;
  mpf_pin_select DUT (.*);
  mpf_pin_model board (.gio_pin_o, .gio_pin_oe_o, .gio_ext, .seg_pin_o, .seg_pin_oe_o, .seg_ext, .gio_pin_i, .seg_pin_i);
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  // ****************************************
  // Shared tasks
  // ****************************************
  // Wait edges, then step past them so outputs have landed
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // Mixed LCD and I/O lines; undriven lines read the board
  task automatic t_lines();
    @(posedge ref_clk_i);
    gio_lcd_sel_i <= 23'h0F0F0F;
    gio_lcd_i <= 23'h2AAAAA;
    gio_out_i <= 23'h3C3C3C;
    gio_oe_i <= 23'h7FFF00;
    gio_ext <= 23'h1234C5;
    w(4);
    chk(gio_pin_o, 23'h0F0F0F & 23'h2AAAAA | 23'h70F0F0 & 23'h3C3C3C);
    chk({gio_pin_oe_o & 23'h70F0F0, gio_in_o & 23'h70F0F0}, {23'h70F000, 23'h3030C0});
    @(posedge ref_clk_i);
    gio_lcd_sel_i <= 23'h7FFFFF; // Specials must still win over LCD
    gio_oe_i <= 23'h7FFFFF;
  endtask
  // Every peripheral on the lines at once, remap both ways
  task automatic t_periph();
    @(posedge ref_clk_i);
    {eeprom_sel_i, eeprom_sck_i, eeprom_sda_low_i, pulse_sel_i} <= 4'hF;
    {aux_pulse_y_i, aux_pulse_x_i, reactive_pulse_out_i, energy_pulse_out_i} <= 4'h5;
    {optical_transmit_sel_i, optical_transmit_i, optical_receive_sel_i} <= 3'h7;
    {uart_remap_enable_i, alt_uart_transmit_i} <= 2'h3;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge ref_clk_i);
      uart_remap_select_i <= s[0];
      gio_ext <= {21'h0, s[0], 1'h0};
      w(4);
      chk({gio_pin_o[GIO_EE_SCK], gio_pin_oe_o[GIO_EE_SCK], gio_pin_o[5], gio_pin_oe_o[5], eeprom_sda_o}, 5'h1A);
      chk({gio_pin_oe_o[GIO_PULSE_Y:GIO_PULSE_E], gio_pin_o[GIO_PULSE_Y:GIO_PULSE_E]}, 8'hF5);
      chk({gio_pin_o[GIO_OPTICAL_TRANSMIT], gio_pin_oe_o[GIO_OPTICAL_TRANSMIT], gio_pin_oe_o[GIO_OPTICAL_RECEIVE]}, 3'h6);
      chk(gio_pin_o[s ? GIO_UART_B : GIO_UART_A], 1'h1);
      chk({gio_pin_oe_o[s ? GIO_UART_A : GIO_UART_B], alt_uart_receive_o, optical_receive_o}, {2'h0, s[0]});
    end
    @(posedge ref_clk_i);
    {uart_remap_enable_i, optical_receive_sel_i, eeprom_sda_low_i} <= 3'h0;
    gio_ext <= 23'h000020; // Pull-up on the released data line
    w(4);
    chk({gio_pin_oe_o[GIO_EE_SDA], eeprom_sda_o, alt_uart_receive_o, optical_receive_o}, 4'h7);
  endtask
  // All segment specials on with the strap, then all back to LCD
  task automatic t_segs();
    @(posedge ref_clk_i);
    {spi_sel_i, spi_port_out_i, mux_sync_enable_i, mux_sync_output_i, clock_out_enable_i, clock_test_output_i} <= 6'h3F;
    {debug_port_enable_pin_i, emulator_trace_clock_i, emulator_data_out_i, emulator_data_oe_i} <= 4'hF;
    {trace_sel_i, trace_sync_out_i, trace_sync_oe_i} <= 3'h7;
    trace_bus_bit_i <= 4'hA;
    seg_ext <= 14'h0089;
    w(6);
    chk(seg_pin_o & 14'h3F72, 14'h3572);
    chk(seg_pin_oe_o & 14'h008F, 14'h0002);
    chk({spi_clk_o, spi_port_select_n_o, spi_port_in_o, emulator_reset_o, debug_port_active_o,
      trace_sync_break_request_o, emulator_serial_data_o}, 7'h5F);
    // Master deselects the port: serial output must let go of the pin
    @(posedge ref_clk_i);
    seg_ext <= 14'h008D;
    w(4);
    chk({seg_pin_oe_o[SEG_SPI_OUT], spi_port_select_n_o}, 2'h1);
    @(posedge ref_clk_i);
    {spi_sel_i, mux_sync_enable_i, clock_out_enable_i, debug_port_enable_pin_i, trace_sel_i} <= 5'h0;
    seg_lcd_i <= 14'h2DB6;
    w(6);
    chk({seg_pin_o, debug_port_active_o, emulator_reset_o}, {14'h2DB6, 2'h0});
  endtask
  // Walk every test mux select
  task automatic t_test_mux_select();
    @(posedge ref_clk_i);
    test_mux_src_i <= 16'hA5C3;
    for (int k = 0; k < TEST_MUX_SELECT_N; k++)
    begin
      @(posedge ref_clk_i);
      test_mux_select_i <= k[3:0];
      w(4);
      chk(test_mux_output_o, 16'hA5C3 >> k & 16'h1);
    end
  endtask
  // Button rise with and without low power, then clear
  task automatic t_button(input logic lp);
    logic [3:0] n;
    n = 4'h0;
    @(posedge ref_clk_i);
    low_power_mode_i <= lp;
    push_button_input_i <= 1'h1;
    repeat (8)
    begin
      w(1);
      n += wake_o;
    end
    chk(n, {3'h0, lp});
    @(posedge ref_clk_i);
    push_button_input_i <= 1'h0;
    w(4);
    chk(button_event_flag_o, 1'h1);
    @(posedge ref_clk_i);
    button_flag_clear_i <= 1'h1;
    @(posedge ref_clk_i);
    button_flag_clear_i <= 1'h0;
    w(3);
    chk(button_event_flag_o, 1'h0);
  endtask
  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Main sequence, with a second reset in mid-run
  initial
  begin
    w(2);
    chk({gio_pin_oe_o, seg_pin_oe_o, button_event_flag_o, wake_o, optical_receive_o}, {37'h0, 3'h1});
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    w(3);
    t_lines();
    t_periph();
    t_segs();
    t_test_mux_select();
    t_button(1'h1);
    t_button(1'h0);
    // Flag left standing into a mid-run reset, then released and used again
    @(posedge ref_clk_i);
    push_button_input_i <= 1'h1;
    w(5);
    chk(button_event_flag_o, 1'h1);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h1;
    w(2);
    chk({seg_pin_oe_o, gio_pin_oe_o, button_event_flag_o}, 38'h0);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    push_button_input_i <= 1'h0;
    w(3);
    chk({button_event_flag_o, wake_o}, 2'h0);
    t_button(1'h1);
    conclude();
  end
endmodule
`default_nettype wire
